// [verilog/dbi_i2c_slave.sv]
// Two-wire bus slave port of the dual step-down converter
`timescale 1ns/1ps
// Function
// R1: Port is a bus target only; never drives the serial clock.
// R2: Accepts standard 100 kbps and fast 400 kbps transfers.
// R3: One state machine serves both speeds; only bit rate differs.
// R4: Only 7-bit addresses; no 10-bit or general call response.
// R5: Strap sets two address LSBs; ground selects 0x60.
// R6: Strap high selects 0x61, strap open selects 0x62.
// R7: Master makes serial clock, address, start and stop conditions.
// R8: Lines are driven open drain only and released when idle.
// R9: Update is start, address, register address byte, data byte.
// R10: Each received byte is acknowledged low during next clock high.
// R11: Written value applies at falling clock edge of data LSB.
// R12: Bus ignored while both enable pins low; else fully working.
// R13: Address mismatch: no acknowledge, transfer ignored until next start.
module dbi_i2c_slave
    import dbi_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Address strap and converter enable pins
    input wire logic [1:0] addrSel,
    input wire logic first_converter_enable_pin,
    input wire logic second_converter_enable_pin,
    // Register write port toward the converter
    output logic wrStrobe,
    output logic [7:0] wrRegAddr,
    output logic [7:0] wrData,
    // Status
    output logic busBusy,
    output logic hwShutdown
);
    import dbi_pkg::*;

    // Whole state of the port
    typedef struct packed {
        logic [2:0] sclSync;
        logic [2:0] sdaSync;
        logic [2:0] en1Sync;
        logic [2:0] en2Sync;
        logic [2:0][1:0] aselSync;
        logic sclLvl;
        logic sdaLvl;
        logic en1Lvl;
        logic en2Lvl;
        logic strapDone;
        logic [2:0] strapFill;
        logic [6:0] myAddr;
        dbi_state_t state;
        logic [1:0] phase;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] regAddr;
        logic [7:0] data;
        logic strobe;
        logic sdaPull;
        logic sdaLow;
        logic busy;
        logic off;
    } dbi_regs_t;

    dbi_regs_t r_reg;
    dbi_regs_t r_next;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic hwOff;

    // New level once the second and third stages agree
    function automatic logic settle(input logic [2:0] s, input logic cur);
        settle = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // Strap code to bus address
    function automatic logic [6:0] strapAddr(input logic [1:0] code);
        logic [6:0] a;
        a = BASE_ADDR;
        case (code)
            ASEL_GROUND: a = BASE_ADDR; // [R5]
            ASEL_HIGH: a = BASE_ADDR | {5'h00, ASEL_HIGH}; // [R6]
            ASEL_OPEN: a = BASE_ADDR | {5'h00, ASEL_OPEN}; // [R6]
            ASEL_BAD: a = BASE_ADDR;
            default: a = BASE_ADDR;
        endcase
        strapAddr = a;
    endfunction

    // Next state of the whole port
    always_comb begin
        r_next = r_reg;
        r_next.strobe = 1'b0;

        // Three-stage sampling of the slow bus pins [R2]
        r_next.sclSync = {r_reg.sclSync[1:0], sclIn};
        r_next.sdaSync = {r_reg.sdaSync[1:0], sdaIn};
        r_next.en1Sync = {r_reg.en1Sync[1:0], first_converter_enable_pin};
        r_next.en2Sync = {r_reg.en2Sync[1:0], second_converter_enable_pin};
        r_next.aselSync = {r_reg.aselSync[1:0], addrSel};
        r_next.sclLvl = settle(r_reg.sclSync, r_reg.sclLvl);
        r_next.sdaLvl = settle(r_reg.sdaSync, r_reg.sdaLvl);
        r_next.en1Lvl = settle(r_reg.en1Sync, r_reg.en1Lvl);
        r_next.en2Lvl = settle(r_reg.en2Sync, r_reg.en2Lvl);

        // Catch the strap once, only after the strap stages hold real samples
        r_next.strapFill = {r_reg.strapFill[1:0], 1'b1};
        if (!r_reg.strapDone && r_reg.strapFill[2]
            && r_reg.aselSync[1] == r_reg.aselSync[2]) begin
            r_next.strapDone = 1'b1;
            r_next.myAddr = strapAddr(r_reg.aselSync[2]);
        end

        // Bus events seen on settled levels
        sclRise = r_next.sclLvl & ~r_reg.sclLvl;
        sclFall = ~r_next.sclLvl & r_reg.sclLvl;
        startCond = r_reg.sclLvl & r_next.sclLvl
            & r_reg.sdaLvl & ~r_next.sdaLvl;
        stopCond = r_reg.sclLvl & r_next.sclLvl
            & ~r_reg.sdaLvl & r_next.sdaLvl;
        hwOff = ~r_next.en1Lvl & ~r_next.en2Lvl;
        r_next.off = hwOff;

        // Transfer sequencing, same for both speeds [R3]
        if (hwOff || !r_reg.strapDone) begin
            // Hardware shutdown or strap not yet caught: bus released and ignored [R12]
            r_next.state = ST_IDLE;
            r_next.sdaPull = 1'b0;
            r_next.busy = 1'b0;
        end else if (startCond) begin
            // Master frames every transfer with a start [R7]
            r_next.state = ST_RX;
            r_next.phase = PH_ADDR;
            r_next.bitCnt = BIT_ZERO;
            r_next.sdaPull = 1'b0;
            r_next.busy = 1'b1;
        end else if (stopCond) begin
            // Stop releases the data line, bus rests high [R8]
            r_next.state = ST_IDLE;
            r_next.sdaPull = 1'b0;
            r_next.busy = 1'b0;
        end else begin
            case (r_reg.state)
                ST_IDLE: begin
                    r_next.sdaPull = 1'b0;
                end
                ST_RX: begin
                    // Data sampled on rising clock, MSB first
                    if (sclRise && r_reg.bitCnt != BYTE_BITS) begin
                        r_next.shift = {r_reg.shift[6:0], r_next.sdaLvl};
                        r_next.bitCnt = r_reg.bitCnt + 4'h1;
                    end
                    // Byte complete at falling edge of its LSB
                    if (sclFall && r_reg.bitCnt == BYTE_BITS) begin
                        case (r_reg.phase)
                            PH_ADDR: begin
                                // Only own 7-bit address, write only [R4]
                                if (r_reg.shift[7:1] == r_reg.myAddr
                                    && r_reg.shift[0] == RW_WRITE) begin
                                    r_next.state = ST_ACK;
                                    r_next.sdaPull = 1'b1; // [R10]
                                end else begin
                                    r_next.state = ST_IGNORE; // [R13]
                                    r_next.sdaPull = 1'b0;
                                end
                            end
                            PH_REG: begin
                                // Register address byte [R9]
                                r_next.regAddr = r_reg.shift;
                                r_next.state = ST_ACK;
                                r_next.sdaPull = 1'b1; // [R10]
                            end
                            PH_DATA: begin
                                // Apply value at data LSB falling edge [R11]
                                r_next.data = r_reg.shift;
                                r_next.strobe = 1'b1;
                                r_next.state = ST_ACK;
                                r_next.sdaPull = 1'b1; // [R10]
                            end
                            default: begin
                                r_next.state = ST_IGNORE;
                                r_next.sdaPull = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Hold low through the ack clock, release after it [R10]
                    if (sclFall) begin
                        r_next.sdaPull = 1'b0;
                        r_next.state = ST_RX;
                        r_next.bitCnt = BIT_ZERO;
                        case (r_reg.phase)
                            PH_ADDR: r_next.phase = PH_REG;
                            PH_REG: r_next.phase = PH_DATA;
                            PH_DATA: r_next.regAddr = r_reg.regAddr + 8'h01;
                            default: r_next.phase = PH_DATA;
                        endcase
                    end
                end
                ST_IGNORE: begin
                    // Line left released until the next start [R13]
                    r_next.sdaPull = 1'b0;
                end
                default: begin
                    r_next.state = ST_IDLE;
                    r_next.sdaPull = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r_reg.sclSync <= SYNC_RST;
            r_reg.sdaSync <= SYNC_RST;
            r_reg.en1Sync <= 3'h0;
            r_reg.en2Sync <= 3'h0;
            r_reg.aselSync <= 6'h00;
            r_reg.sclLvl <= 1'b1;
            r_reg.sdaLvl <= 1'b1;
            r_reg.en1Lvl <= 1'b0;
            r_reg.en2Lvl <= 1'b0;
            r_reg.strapDone <= 1'b0;
            r_reg.strapFill <= '0;
            r_reg.myAddr <= BASE_ADDR;
            r_reg.state <= ST_IDLE;
            r_reg.phase <= PH_ADDR;
            r_reg.bitCnt <= BIT_ZERO;
            r_reg.shift <= BYTE_RST;
            r_reg.regAddr <= BYTE_RST;
            r_reg.data <= BYTE_RST;
            r_reg.strobe <= 1'b0;
            r_reg.sdaPull <= 1'b0;
            r_reg.sdaLow <= 1'b0;
            r_reg.busy <= 1'b0;
            r_reg.off <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register; clock never driven [R1]
    assign sdaOut = r_reg.sdaLow; // [R8]
    assign sdaOe = r_reg.sdaPull; // [R8]
    assign wrStrobe = r_reg.strobe;
    assign wrRegAddr = r_reg.regAddr;
    assign wrData = r_reg.data;
    assign busBusy = r_reg.busy;
    assign hwShutdown = r_reg.off;

endmodule

// [verilog/dbi_pkg.sv]
// Constants and types for the dual buck two-wire slave port
package dbi_pkg;

    // Bus speeds the port follows; both use one protocol
    localparam int STD_KBPS = 100;
    localparam int FAST_KBPS = 400;
    localparam int CLK_KHZ = 125000;
    // Reference cycles in one fast-mode clock half period (round down)
    localparam int FAST_HALF_CYC = CLK_KHZ / (2 * FAST_KBPS);

    // Bus address: upper five bits fixed, two low bits from the strap
    localparam logic [6:0] BASE_ADDR = 7'h60;
    localparam logic [1:0] ASEL_GROUND = 2'h0;
    localparam logic [1:0] ASEL_HIGH = 2'h1;
    localparam logic [1:0] ASEL_OPEN = 2'h2;
    localparam logic [1:0] ASEL_BAD = 2'h3;

    // Byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic RW_WRITE = 1'b0;

    // Which byte of a transfer is being received
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_REG = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h7;

    // Transfer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RX = 4'h2,
        ST_ACK = 4'h4,
        ST_IGNORE = 4'h8
    } dbi_state_t;

endpackage

// [sim/dbi_i2c_slave_checker.sv]
// Assertion checker for the two-wire slave port
`timescale 1ns/1ps
module dbi_i2c_slave_checker (
    // Clock, reset and bus pins
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Strap and enable pins
    input wire logic [1:0] addrSel,
    input wire logic first_converter_enable_pin,
    input wire logic second_converter_enable_pin,
    // Write port and status
    input wire logic wrStrobe,
    input wire logic [7:0] wrRegAddr,
    input wire logic [7:0] wrData,
    input wire logic busBusy,
    input wire logic hwShutdown
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Bus conditions and both enables low, seen on the pins
    sequence startSeen;
        $fell(sdaIn) && sclIn;
    endsequence
    sequence stopSeen;
        $rose(sdaIn) && sclIn;
    endsequence
    sequence bothOff;
        !first_converter_enable_pin && !second_converter_enable_pin;
    endsequence
    AST_DRIVE_LOW: assert property (sdaOut == 1'b0)
        else $error("data drive value not low");
    AST_STROBE_PULSE: assert property (wrStrobe |=> !wrStrobe)
        else $error("write strobe longer than one cycle");
    AST_STROBE_AT_FALL: assert property (wrStrobe |-> !sclIn)
        else $error("write strobe outside clock low phase");
    AST_STROBE_ACK: assert property (wrStrobe |-> ##[0:3] sdaOe)
        else $error("data byte applied without acknowledge");
    AST_ACK_EDGES: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("acknowledge changed during clock high");
    AST_DATA_HELD: assert property ($changed(wrData) |-> wrStrobe)
        else $error("write data changed without strobe");
    AST_IDLE_QUIET: assert property (!busBusy |-> !sdaOe)
        else $error("data line pulled outside a transfer");
    AST_OFF_SET: assert property (bothOff [*6] |-> hwShutdown)
        else $error("shutdown not flagged with both enables low");
    AST_OFF_QUIET: assert property (hwShutdown |-> !sdaOe && !wrStrobe)
        else $error("bus activity during hardware shutdown");
    AST_BUSY_START: assert property (startSeen ##0 !hwShutdown |->
        ##[2:6] busBusy)
        else $error("start condition not taken");
    AST_BUSY_STOP: assert property (stopSeen |-> ##[2:6] !busBusy)
        else $error("stop condition not taken");
endmodule
bind dbi_i2c_slave dbi_i2c_slave_checker chk (.ref_clk, .nrst, .sclIn,
    .sdaIn, .sdaOut, .sdaOe, .addrSel, .first_converter_enable_pin,
    .second_converter_enable_pin, .wrStrobe, .wrRegAddr, .wrData,
    .busBusy, .hwShutdown);

// [sim/dbi_i2c_master_model.sv]
// Bus master model driving serial clock and open-drain data
`timescale 1ns/1ps
module dbi_i2c_master_model (
    // Clock and bus
    input wire logic ref_clk,
    input wire logic sdaBus,
    output logic sclPin,
    output logic sdaPull
);
    int half = 10;
    // Idle bus: both lines released high
    initial begin
        sclPin = 1'b1;
        sdaPull = 1'b0;
    end
    // Wait reference cycles
    task automatic waitCyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Start or repeated start
    task automatic start();
        sdaPull <= 1'b0;
        waitCyc(half);
        sclPin <= 1'b1;
        waitCyc(half);
        sdaPull <= 1'b1;
        waitCyc(half);
        sclPin <= 1'b0;
    endtask
    // One clock: data set in low phase, line read at end of high
    task automatic bitx(input logic b, output logic r);
        waitCyc(2);
        sdaPull <= !b;
        waitCyc(half - 2);
        sclPin <= 1'b1;
        waitCyc(half);
        r = sdaBus;
        sclPin <= 1'b0;
    endtask
    // Byte MSB first, then acknowledge clock
    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], r);
        end
        bitx(1'b1, r);
        ack = !r;
    endtask
    // Stop condition
    task automatic stop();
        waitCyc(2);
        sdaPull <= 1'b1;
        waitCyc(half - 2);
        sclPin <= 1'b1;
        waitCyc(half);
        sdaPull <= 1'b0;
        waitCyc(half);
    endtask
endmodule

// [sim/dbi_i2c_slave_test.sv]
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module dbi_i2c_slave_test;
    import dbi_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] addrSel = 2'h0;
    logic enOne = 1'b1;
    logic enTwo = 1'b1;
    logic sclPin, sdaPull, sdaBus, sdaOut, sdaOe, wrStrobe, busBusy;
    logic hwShutdown;
    logic [7:0] wrRegAddr, wrData;
    logic [15:0] expQ[$];
    int badCount = 0;
    int checkCount = 0;
    logic [6:0] adrTab[4] = '{7'h60, 7'h61, 7'h62, 7'h60};
    logic [7:0] refTab[3] = '{8'hc1, 8'h00, 8'hf0};
    // Clock and wired data line with pull-up
    always #4 ref_clk = ~ref_clk;
    assign sdaBus = (sdaOe ? sdaOut : 1'b1) && !sdaPull;
    dbi_i2c_slave uut (.ref_clk(ref_clk), .nrst(nrst), .sclIn(sclPin),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
        .first_converter_enable_pin(enOne),
        .second_converter_enable_pin(enTwo), .wrStrobe(wrStrobe),
        .wrRegAddr(wrRegAddr), .wrData(wrData), .busBusy(busBusy),
        .hwShutdown(hwShutdown));
    dbi_i2c_master_model mst (.ref_clk(ref_clk), .sdaBus(sdaBus),
        .sclPin(sclPin), .sdaPull(sdaPull));
    // Count one comparison, report a mismatch
    task automatic tally(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write result: register address and data
    task automatic cmpWrite(input logic [15:0] got, input logic [15:0] exp);
        tally(got, exp);
    endtask
    // Acknowledge seen by the master
    task automatic cmpAck(input logic got, input logic exp);
        tally({15'h0, got}, {15'h0, exp});
    endtask
    // Busy and shutdown status
    task automatic cmpStatus(input logic [1:0] got, input logic [1:0] exp);
        tally({14'h0, got}, {14'h0, exp});
    endtask
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Each write strobe against the oldest note
    always @(posedge ref_clk) begin
        if (wrStrobe === 1'b1) begin
            cmpWrite({wrRegAddr, wrData},
                expQ.size() ? expQ.pop_front() : 16'hxxxx);
        end
    end
    task automatic doReset();
        nrst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (12) @(posedge ref_clk);
    endtask
    // Address byte, register byte, n data bytes; ok says acked
    task automatic xfer(input logic [7:0] adr, input logic [7:0] rg,
                        input int n, input logic ok);
        logic a;
        logic enOn;
        logic [7:0] d;
        enOn = enOne | enTwo;
        mst.start();
        cmpStatus({busBusy, hwShutdown}, {enOn, !enOn});
        mst.sendByte(adr, a);
        cmpAck(a, ok);
        mst.sendByte(rg, a);
        cmpAck(a, ok);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            if (ok) expQ.push_back({rg + 8'(k), d});
            mst.sendByte(d, a);
            cmpAck(a, ok);
        end
        mst.stop();
        cmpStatus({busBusy, hwShutdown}, {1'b0, !enOn});
    endtask
    initial begin
        void'($urandom(86));
        for (int s = 0; s < 4; s++) begin
            addrSel <= 2'(s);
            doReset();
            xfer({adrTab[s], 1'b0}, 8'($urandom), 1 + s, 1'b1);
            xfer({7'h63, 1'b0}, 8'h01, 1, 1'b0);
        end
        foreach (refTab[i]) xfer(refTab[i], 8'h02, 1, 1'b0);
        xfer(8'hc0, 8'hfe, 3, 1'b1);
        enOne <= 1'b0;
        enTwo <= 1'b0;
        repeat (10) @(posedge ref_clk);
        xfer(8'hc0, 8'h00, 1, 1'b0);
        enTwo <= 1'b1;
        repeat (10) @(posedge ref_clk);
        xfer(8'hc0, 8'h03, 1, 1'b1);
        mst.half = 156;
        xfer(8'hc0, 8'h01, 1, 1'b1);
        mst.half = 625;
        xfer(8'hc0, 8'h04, 1, 1'b1);
        cmpWrite(16'(expQ.size()), 16'h0000);
        endOfTest();
    end
    // Watchdog against a hung transfer
    initial begin
        repeat (95000) @(posedge ref_clk);
        badCount++;
        endOfTest();
    end
endmodule
